/* pet_pkg.sv */
/*
  Constants, register map and state types for the pulse edge timer interrupt block.
  Assumes a single clock domain and AXI4-Lite register access with 32-bit data.
*/
`default_nettype none
package pet_pkg;
  localparam int ADDR_W  = 18;
  localparam int IDX_W   = 16;
  localparam int DATA_W  = 32;
  localparam int CNT_W   = 16;
  localparam int EVT_W   = 3;

  // register indexes, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_EDGE_SEL   = 16'hfff2;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN     = 16'hfff4;
  localparam logic [IDX_W-1:0] IDX_IRQ_REQ    = 16'hfff7;
  localparam logic [IDX_W-1:0] IDX_CTRL       = 16'h0010;
  localparam logic [IDX_W-1:0] IDX_COUNT      = 16'h0011;
  localparam logic [IDX_W-1:0] IDX_COMPARE    = 16'h0012;
  localparam logic [IDX_W-1:0] IDX_EVT_STATUS = 16'h0013;
  localparam logic [IDX_W-1:0] IDX_EVT_MASK   = 16'h0014;

  // field positions
  localparam int BIT_EDGE_POL  = 6;
  localparam int BIT_HT_IRQ    = 3;
  localparam int BIT_CLR_MATCH = 0;
  localparam int BIT_OVF_IE    = 1;
  localparam int BIT_OVF_FLAG  = 2;
  localparam int EVT_MATCH     = 0;
  localparam int EVT_OVF       = 1;
  localparam int EVT_EDGE      = 2;

  // reset and fixed values
  localparam logic [7:0]       RST_BYTE = 8'h00;
  localparam logic [CNT_W-1:0] RST_CNT  = 16'h0000;
  localparam logic [CNT_W-1:0] RST_CMP  = 16'hffff;
  localparam logic [CNT_W-1:0] CNT_ONES = 16'hffff;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [EVT_W-1:0] RST_EVT  = 3'h0;
  localparam logic [1:0]       RESP_OKAY   = 2'h0;
  localparam logic [1:0]       RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic prev;
    logic armed;
  } pet_edge_t;

  typedef struct packed {
    logic              aw_full;
    logic [IDX_W-1:0]  aw_idx;
    logic              w_full;
    logic [DATA_W-1:0] w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } pet_slv_t;

  typedef struct packed {
    logic [7:0]       edge_sel;
    logic [7:0]       irq_en;
    logic             irq_flag;
    logic             clr_match;
    logic             ovf_ie;
    logic             ovf_flag;
    logic [CNT_W-1:0] counter;
    logic [CNT_W-1:0] compare;
    logic [EVT_W-1:0] evt_status;
    logic [EVT_W-1:0] evt_mask;
  } pet_core_t;
endpackage : pet_pkg
`default_nettype wire

/* pet_reg_if.sv */
/*
  Register access carrier between the bus slave and the core.
  Assumes one write and one read strobe per access, both one cycle long.
*/
`timescale 1ns/100ps
`default_nettype none
interface pet_reg_if;
  import pet_pkg::*;
  logic              wr_en;
  logic [IDX_W-1:0]  wr_idx;
  logic [DATA_W-1:0] wr_data;
  logic [3:0]        wr_strb;
  logic              wr_ok;
  logic              rd_en;
  logic [IDX_W-1:0]  rd_idx;
  logic [DATA_W-1:0] rd_data;
  logic              rd_ok;
  modport slave (output wr_en, wr_idx, wr_data, wr_strb, rd_en, rd_idx, input wr_ok, rd_data, rd_ok);
  modport core  (input wr_en, wr_idx, wr_data, wr_strb, rd_en, rd_idx, output wr_ok, rd_data, rd_ok);
endinterface : pet_reg_if
`default_nettype wire

/* pet_edge_det.sv */
/*
  Edge detector for the event input, polarity chosen by software.
  Assumes the pin input is already synchronous to aclk.
*/
`timescale 1ns/100ps
`default_nettype none
module pet_edge_det (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin,
  input  wire logic rising_sel,
  output logic      pulse
);
  import pet_pkg::*;
  pet_edge_t r;
  pet_edge_t next_r;

  always_comb begin
    next_r       = r;
    next_r.prev  = pin;
    next_r.armed = 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // no edge on the first cycle after reset
  assign pulse = r.armed & (rising_sel ? (~r.prev & pin) : (r.prev & ~pin));

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_rise_edge: assert property (r.armed && rising_sel && $rose(pin) |-> pulse)
    else $error("rising edge missed");
  chk_fall_edge: assert property (r.armed && !rising_sel && $fell(pin) |-> pulse)
    else $error("falling edge missed");
  chk_wrong_edge: assert property (pulse |-> (rising_sel ? $rose(pin) : $fell(pin)))
    else $error("pulse on wrong polarity");
endmodule : pet_edge_det
`default_nettype wire

/* pet_axil_slave.sv */
/*
  AXI4-Lite slave turning bus accesses into one-cycle register strobes.
  Assumes the core answers wr_ok, rd_data and rd_ok combinationally.
*/
`timescale 1ns/100ps
`default_nettype none
module pet_axil_slave (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [pet_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [pet_pkg::DATA_W-1:0] wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  input  wire logic [pet_pkg::ADDR_W-1:0] araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [pet_pkg::DATA_W-1:0]      rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  pet_reg_if.slave                        regs
);
  import pet_pkg::*;
  pet_slv_t r;
  pet_slv_t next_r;
  logic     wr_fire;
  logic     ar_fire;

  assign awready = ~r.aw_full;
  assign wready  = ~r.w_full;
  assign arready = ~r.rvalid;
  assign bvalid  = r.bvalid;
  assign bresp   = r.bresp;
  assign rvalid  = r.rvalid;
  assign rdata   = r.rdata;
  assign rresp   = r.rresp;
  assign wr_fire = r.aw_full & r.w_full & ~r.bvalid;
  assign ar_fire = arvalid & ~r.rvalid;

  assign regs.wr_en   = wr_fire;
  assign regs.wr_idx  = r.aw_idx;
  assign regs.wr_data = r.w_data;
  assign regs.wr_strb = r.w_strb;
  assign regs.rd_en   = ar_fire;
  assign regs.rd_idx  = araddr[ADDR_W-1:2];

  always_comb begin
    next_r = r;
    if (awvalid && !r.aw_full) begin
      next_r.aw_full = 1'b1;
      next_r.aw_idx  = awaddr[ADDR_W-1:2];
    end
    if (wvalid && !r.w_full) begin
      next_r.w_full = 1'b1;
      next_r.w_data = wdata;
      next_r.w_strb = wstrb;
    end
    if (r.bvalid && bready) begin
      next_r.bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_r.aw_full = 1'b0;
      next_r.w_full  = 1'b0;
      next_r.bvalid  = 1'b1;
      next_r.bresp   = regs.wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (r.rvalid && rready) begin
      next_r.rvalid = 1'b0;
    end
    if (ar_fire) begin
      next_r.rvalid = 1'b1;
      next_r.rdata  = regs.rd_data;
      next_r.rresp  = regs.rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule : pet_axil_slave
`default_nettype wire

/* pet_top.sv */
/*
  Event counter with edge select and high timer interrupt request logic.
  Assumes an AXI4-Lite master on the register side and a synchronous pulse pin.
*/
`timescale 1ns/100ps
`default_nettype none
module pet_top (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [pet_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [pet_pkg::DATA_W-1:0] wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  input  wire logic [pet_pkg::ADDR_W-1:0] araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [pet_pkg::DATA_W-1:0]      rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  input  wire logic                       event_input_pin,
  output logic                            irq
);
  import pet_pkg::*;

  pet_core_t        r;
  pet_core_t        next_r;
  pet_reg_if        regs ();
  logic             edge_pulse;
  logic [CNT_W-1:0] inc;
  logic             match;
  logic             ovf;
  logic             lane0;
  logic             lane1;
  logic             cnt_wr;
  logic             req_clr;
  logic             flag_set;
  logic [EVT_W-1:0] evts;

  pet_axil_slave u_slave (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .regs    (regs.slave)
  );

  pet_edge_det u_edge (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .pin        (event_input_pin),
    .rising_sel (r.edge_sel[BIT_EDGE_POL]),
    .pulse      (edge_pulse)
  );

  // counter events
  assign inc      = CNT_W'(r.counter + 1'b1);
  assign match    = edge_pulse & (inc == r.compare);
  assign ovf      = edge_pulse & (r.counter == CNT_ONES);
  assign flag_set = match | (ovf & r.ovf_ie);
  always_comb begin
    evts            = RST_EVT;
    evts[EVT_MATCH] = match;
    evts[EVT_OVF]   = ovf;
    evts[EVT_EDGE]  = edge_pulse;
  end

  // write decode
  assign lane0   = regs.wr_en & regs.wr_strb[0];
  assign lane1   = regs.wr_en & regs.wr_strb[1];
  assign cnt_wr  = (lane0 | lane1) & (regs.wr_idx == IDX_COUNT);
  assign req_clr = lane0 & (regs.wr_idx == IDX_IRQ_REQ) & ~regs.wr_data[BIT_HT_IRQ];

  // address map check
  always_comb begin
    case (regs.wr_idx)
      IDX_EDGE_SEL, IDX_IRQ_EN, IDX_IRQ_REQ, IDX_CTRL,
      IDX_COUNT, IDX_COMPARE, IDX_EVT_STATUS, IDX_EVT_MASK: regs.wr_ok = 1'b1;
      default: regs.wr_ok = 1'b0;
    endcase
  end

  // read mux
  always_comb begin
    regs.rd_data = '0;
    regs.rd_ok   = 1'b1;
    case (regs.rd_idx)
      IDX_EDGE_SEL:   regs.rd_data[7:0] = r.edge_sel;
      IDX_IRQ_EN:     regs.rd_data[7:0] = r.irq_en;
      IDX_IRQ_REQ:    regs.rd_data[BIT_HT_IRQ] = r.irq_flag;
      IDX_CTRL: begin
        regs.rd_data[BIT_CLR_MATCH] = r.clr_match;
        regs.rd_data[BIT_OVF_IE]    = r.ovf_ie;
        regs.rd_data[BIT_OVF_FLAG]  = r.ovf_flag;
      end
      IDX_COUNT:      regs.rd_data[CNT_W-1:0] = r.counter;
      IDX_COMPARE:    regs.rd_data[CNT_W-1:0] = r.compare;
      IDX_EVT_STATUS: regs.rd_data[EVT_W-1:0] = r.evt_status;
      IDX_EVT_MASK:   regs.rd_data[EVT_W-1:0] = r.evt_mask;
      default:        regs.rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    next_r = r;
    // counting, clear on match wins over increment
    if (edge_pulse) begin
      next_r.counter = (match && r.clr_match) ? CNT_ZERO : inc;
    end
    // software writes
    if (lane0) begin
      case (regs.wr_idx)
        IDX_EDGE_SEL: next_r.edge_sel = regs.wr_data[7:0];
        IDX_IRQ_EN:   next_r.irq_en = regs.wr_data[7:0];
        IDX_IRQ_REQ: begin
          if (!regs.wr_data[BIT_HT_IRQ]) begin
            next_r.irq_flag = 1'b0;
          end
        end
        IDX_CTRL: begin
          next_r.clr_match = regs.wr_data[BIT_CLR_MATCH];
          next_r.ovf_ie    = regs.wr_data[BIT_OVF_IE];
          if (!regs.wr_data[BIT_OVF_FLAG]) begin
            next_r.ovf_flag = 1'b0;
          end
        end
        IDX_COUNT:      next_r.counter[7:0] = regs.wr_data[7:0];
        IDX_COMPARE:    next_r.compare[7:0] = regs.wr_data[7:0];
        IDX_EVT_STATUS: next_r.evt_status = r.evt_status & ~regs.wr_data[EVT_W-1:0];
        IDX_EVT_MASK:   next_r.evt_mask = regs.wr_data[EVT_W-1:0];
        default: begin
        end
      endcase
    end
    if (lane1) begin
      case (regs.wr_idx)
        IDX_COUNT:   next_r.counter[CNT_W-1:8] = regs.wr_data[CNT_W-1:8];
        IDX_COMPARE: next_r.compare[CNT_W-1:8] = regs.wr_data[CNT_W-1:8];
        default: begin
        end
      endcase
    end
    // hardware sets win over software clears
    if (flag_set) begin
      next_r.irq_flag = 1'b1;
    end
    if (ovf) begin
      next_r.ovf_flag = 1'b1;
    end
    next_r.evt_status = next_r.evt_status | evts;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r.edge_sel   <= RST_BYTE;
      r.irq_en     <= RST_BYTE;
      r.irq_flag   <= 1'b0;
      r.clr_match  <= 1'b0;
      r.ovf_ie     <= 1'b0;
      r.ovf_flag   <= 1'b0;
      r.counter    <= RST_CNT;
      r.compare    <= RST_CMP;
      r.evt_status <= RST_EVT;
      r.evt_mask   <= RST_EVT;
    end else begin
      r <= next_r;
    end
  end

  // request gated by enable, plus masked event status
  assign irq = (r.irq_flag & r.irq_en[BIT_HT_IRQ]) | (|(r.evt_status & r.evt_mask));

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_count_step: assert property (edge_pulse && !cnt_wr && !(match && r.clr_match)
      |=> r.counter == CNT_W'($past(r.counter) + 1'b1))
    else $error("counter did not advance on edge");
  chk_count_idle: assert property (!edge_pulse && !cnt_wr |=> $stable(r.counter))
    else $error("counter moved without edge");
  chk_irq_gate: assert property (!r.irq_en[BIT_HT_IRQ] && !(|(r.evt_status & r.evt_mask)) |-> !irq)
    else $error("interrupt passed while disabled");
  chk_flag_set: assert property (match |=> r.irq_flag)
    else $error("match did not set request flag");
  chk_flag_hold: assert property (r.irq_flag && !req_clr |=> r.irq_flag)
    else $error("request flag dropped without clear");
  chk_flag_clear: assert property (req_clr && !flag_set |=> !r.irq_flag)
    else $error("request flag not cleared by zero write");
  chk_ovf_flags: assert property (ovf |=> r.ovf_flag && (r.irq_flag || !$past(r.ovf_ie)))
    else $error("overflow flags wrong");
  chk_irq_raise: assert property (r.irq_flag && r.irq_en[BIT_HT_IRQ] |-> irq)
    else $error("interrupt not raised");
  chk_match_clear: assert property (match && r.clr_match && !cnt_wr |=> r.counter == CNT_ZERO)
    else $error("counter not cleared on match");

  // register writes land where addressed
  chk_sel_write: assert property (lane0 && regs.wr_idx == IDX_EDGE_SEL
      |=> r.edge_sel == $past(regs.wr_data[7:0]))
    else $error("edge select write lost");
  chk_sel_hold: assert property (!(lane0 && regs.wr_idx == IDX_EDGE_SEL)
      |=> $stable(r.edge_sel))
    else $error("edge select changed without write");
  chk_en_write: assert property (lane0 && regs.wr_idx == IDX_IRQ_EN
      |=> r.irq_en == $past(regs.wr_data[7:0]))
    else $error("enable write lost");
  chk_en_hold: assert property (!(lane0 && regs.wr_idx == IDX_IRQ_EN)
      |=> $stable(r.irq_en))
    else $error("enable changed without write");
  chk_cmp_hold: assert property (!(regs.wr_en && regs.wr_idx == IDX_COMPARE)
      |=> $stable(r.compare))
    else $error("compare changed without write");
  chk_mask_write: assert property (lane0 && regs.wr_idx == IDX_EVT_MASK
      |=> r.evt_mask == $past(regs.wr_data[EVT_W-1:0]))
    else $error("event mask write lost");
  chk_ctrl_write: assert property (lane0 && regs.wr_idx == IDX_CTRL
      |=> r.clr_match == $past(regs.wr_data[BIT_CLR_MATCH]) && r.ovf_ie == $past(regs.wr_data[BIT_OVF_IE]))
    else $error("control write lost");

  // counter writes and wrap
  chk_count_low: assert property (lane0 && regs.wr_idx == IDX_COUNT
      |=> r.counter[7:0] == $past(regs.wr_data[7:0]))
    else $error("count low byte write lost");
  chk_count_high: assert property (lane1 && regs.wr_idx == IDX_COUNT
      |=> r.counter[CNT_W-1:8] == $past(regs.wr_data[CNT_W-1:8]))
    else $error("count high byte write lost");
  chk_wrap_zero: assert property (ovf && !cnt_wr && !(match && r.clr_match)
      |=> r.counter == CNT_ZERO)
    else $error("counter did not wrap to zero");
  chk_keep_count: assert property (match && !r.clr_match && !cnt_wr
      |=> r.counter == $past(r.compare))
    else $error("counter cleared without clear on match");

  // request and overflow flags
  chk_flag_source: assert property (!r.irq_flag && !flag_set
      |=> !r.irq_flag)
    else $error("request flag set without event");
  chk_flag_cause: assert property ($rose(r.irq_flag)
      |-> $past(flag_set))
    else $error("request flag rose without event");
  chk_ovf_request: assert property (ovf && r.ovf_ie
      |=> r.irq_flag)
    else $error("enabled overflow did not request");
  chk_ovf_quiet: assert property (ovf && !r.ovf_ie && !match && !r.irq_flag
      |=> !r.irq_flag)
    else $error("disabled overflow requested");
  chk_ovf_hold: assert property (r.ovf_flag && !(lane0 && regs.wr_idx == IDX_CTRL)
      |=> r.ovf_flag)
    else $error("overflow flag dropped without clear");
  chk_ovf_clear: assert property (lane0 && regs.wr_idx == IDX_CTRL && !regs.wr_data[BIT_OVF_FLAG] && !ovf
      |=> !r.ovf_flag)
    else $error("overflow flag not cleared by zero write");
  chk_ovf_cause: assert property ($rose(r.ovf_flag)
      |-> $past(ovf))
    else $error("overflow flag rose without wrap");

  // interrupt output and event status
  chk_irq_low: assert property (!r.irq_flag && !(|(r.evt_status & r.evt_mask))
      |-> !irq)
    else $error("interrupt without cause");
  chk_irq_masked: assert property (r.irq_flag && !r.irq_en[BIT_HT_IRQ] && !(|(r.evt_status & r.evt_mask))
      |-> !irq)
    else $error("disabled request reached interrupt");
  chk_irq_event: assert property (|(r.evt_status & r.evt_mask)
      |-> irq)
    else $error("unmasked event did not interrupt");
  chk_evt_keep: assert property (!(lane0 && regs.wr_idx == IDX_EVT_STATUS)
      |=> ($past(r.evt_status) & ~r.evt_status) == RST_EVT)
    else $error("event status dropped without clear");
  chk_evt_set: assert property (|evts
      |=> (r.evt_status & $past(evts)) == $past(evts))
    else $error("event not recorded");
  chk_evt_edge: assert property (edge_pulse
      |=> r.evt_status[EVT_EDGE])
    else $error("edge event not recorded");

  // unmapped accesses
  chk_read_map: assert property (regs.rd_en && !regs.rd_ok
      |-> regs.rd_data == '0)
    else $error("unmapped read returned data");
  chk_write_map: assert property (regs.wr_en && !regs.wr_ok
      |=> $stable(r.edge_sel) && $stable(r.irq_en) && $stable(r.compare))
    else $error("unmapped write changed a register");
endmodule : pet_top
`default_nettype wire

/* pet_pulse_src.sv */
/*
  Pulse source model driving the event input pin.
  Assumes the bench asks for a count of level changes; one comes every two clocks.
*/
`timescale 1ns/100ps
`default_nettype none
module pet_pulse_src (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       go,
  input  wire logic [7:0] toggles,
  output logic            pin,
  output logic            busy
);
  logic [7:0] left;
  logic       gap;
  assign busy = (left != 8'h00);
  // level changes spaced two clocks apart, pin idles low after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin  <= 1'b0;
      left <= 8'h00;
      gap  <= 1'b0;
    end else if (go && !busy) begin
      left <= toggles;
      gap  <= 1'b0;
    end else if (busy) begin
      gap <= ~gap;
      if (gap) begin
        pin  <= ~pin;
        left <= left - 8'h01;
      end
    end
  end
endmodule : pet_pulse_src
`default_nettype wire

/* pulse_edge_timer_irq_bench.sv */
/*
  Self-checking bench for pet_top: register table, then edge, match, clear and overflow cases.
  Assumes pet_pkg, pet_pulse_src and the design files are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module pulse_edge_timer_irq_bench;
  import pet_pkg::*;
  typedef struct packed {
    logic [15:0] idx;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0]  r;
  } pet_row_t;
  logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready, pin, irq, src_go, src_busy;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, rd_d;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, rd_r;
  logic [7:0]        src_n;
  int                n_errors, checked;
  pet_row_t rows [7] = '{
    '{IDX_EDGE_SEL, 32'h0000_0040, 32'h0000_0040, RESP_OKAY},
    '{IDX_IRQ_EN, 32'h0000_00ff, 32'h0000_00ff, RESP_OKAY},
    '{IDX_IRQ_REQ, 32'h0000_00ff, 32'h0000_0000, RESP_OKAY},
    '{IDX_COMPARE, 32'h0000_1234, 32'h0000_1234, RESP_OKAY},
    '{IDX_COUNT, 32'h0000_abcd, 32'h0000_abcd, RESP_OKAY},
    '{IDX_EVT_MASK, 32'h0000_0000, 32'h0000_0000, RESP_OKAY},
    '{16'h0020, 32'h0000_0005, 32'h0000_0000, RESP_SLVERR}};

  pet_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .event_input_pin(pin), .irq(irq));
  pet_pulse_src src (.aclk(aclk), .aresetn(aresetn), .go(src_go), .toggles(src_n), .pin(pin),
    .busy(src_busy));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic tmo(input int n);
    if (n >= 200) begin
      n_errors++;
      $display("BAD wait expected handshake seen timeout");
      report_and_stop();
    end
  endtask : tmo

  task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
    int   n;
    logic a, w;
    a = 1'b1;
    w = 1'b1;
    n = 0;
    awaddr  <= {idx, 2'b00};
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hf;
    wvalid  <= 1'b1;
    while ((a || w) && n < 200) begin
      @(posedge aclk);
      n++;
      if (a && awready) begin
        a = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
      n++;
    end while (!bvalid && n < 200);
    tmo(n);
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wr

  task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!arready && n < 200);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (!rvalid && n < 200);
    tmo(n);
    d = rdata;
    r = rresp;
  endtask : rd

  task automatic rc(input string nm, input logic [15:0] idx, input logic [31:0] e);
    rd(idx, rd_d, rd_r);
    chk(nm, e, rd_d);
    chk(nm, {30'h0, RESP_OKAY}, {30'h0, rd_r});
  endtask : rc

  task automatic pulse(input logic [7:0] k);
    int n;
    n = 0;
    src_n  <= k;
    src_go <= 1'b1;
    @(posedge aclk);
    src_go <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (src_busy && n < 200);
    tmo(n);
    repeat (3) @(posedge aclk);
  endtask : pulse

  initial begin
    {aresetn, awvalid, wvalid, arvalid, src_go} = 5'h00;
    {bready, rready} = 2'h3;
    {awaddr, araddr, wdata, wstrb, src_n} = '0;
    n_errors = 0;
    checked  = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].d, rows[i].r);
      rd(rows[i].idx, rd_d, rd_r);
      chk("row data", rows[i].e, rd_d);
      chk("row resp", {30'h0, rows[i].r}, {30'h0, rd_r});
    end
    $display("test register table done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc("edge_sel reset", IDX_EDGE_SEL, 32'h0);
    rc("irq_en reset", IDX_IRQ_EN, 32'h0);
    rc("compare reset", IDX_COMPARE, 32'h0000_ffff);
    rc("count reset", IDX_COUNT, 32'h0);
    chk("irq reset", 32'h0, {31'h0, irq});
    $display("test reset done");
    pulse(8'h01);
    rc("count rise ignored", IDX_COUNT, 32'h0);
    pulse(8'h01);
    rc("count fall", IDX_COUNT, 32'h1);
    wr(IDX_EDGE_SEL, 32'h40, RESP_OKAY);
    pulse(8'h04);
    rc("count rising", IDX_COUNT, 32'h3);
    $display("test edge select done");
    wr(IDX_COMPARE, 32'h4, RESP_OKAY);
    pulse(8'h02);
    rc("flag on match", IDX_IRQ_REQ, 32'h8);
    chk("irq disabled", 32'h0, {31'h0, irq});
    wr(IDX_IRQ_EN, 32'h08, RESP_OKAY);
    chk("irq enabled", 32'h1, {31'h0, irq});
    wr(IDX_IRQ_REQ, 32'h08, RESP_OKAY);
    chk("irq after write 1", 32'h1, {31'h0, irq});
    wr(IDX_IRQ_REQ, 32'h00, RESP_OKAY);
    chk("irq after clear", 32'h0, {31'h0, irq});
    rc("flag cleared", IDX_IRQ_REQ, 32'h0);
    $display("test match irq done");
    wr(IDX_CTRL, 32'h1, RESP_OKAY);
    wr(IDX_COUNT, 32'h10, RESP_OKAY);
    wr(IDX_COMPARE, 32'h11, RESP_OKAY);
    pulse(8'h02);
    rc("count clear on match", IDX_COUNT, 32'h0);
    chk("irq on match", 32'h1, {31'h0, irq});
    wr(IDX_IRQ_REQ, 32'h00, RESP_OKAY);
    wr(IDX_CTRL, 32'h0, RESP_OKAY);
    $display("test clear on match done");
    wr(IDX_COMPARE, 32'h5, RESP_OKAY);
    wr(IDX_COUNT, 32'hffff, RESP_OKAY);
    pulse(8'h02);
    rc("count wrap", IDX_COUNT, 32'h0);
    rc("ovf flag", IDX_CTRL, 32'h4);
    rc("no flag ovf off", IDX_IRQ_REQ, 32'h0);
    wr(IDX_CTRL, 32'h2, RESP_OKAY);
    wr(IDX_COUNT, 32'hffff, RESP_OKAY);
    pulse(8'h02);
    rc("ovf flag on", IDX_CTRL, 32'h6);
    rc("flag ovf on", IDX_IRQ_REQ, 32'h8);
    chk("irq ovf", 32'h1, {31'h0, irq});
    wr(IDX_IRQ_EN, 32'h00, RESP_OKAY);
    chk("irq masked", 32'h0, {31'h0, irq});
    $display("test overflow done");
    rc("event status", IDX_EVT_STATUS, 32'h7);
    wr(IDX_EVT_MASK, 32'h2, RESP_OKAY);
    chk("irq event", 32'h1, {31'h0, irq});
    wr(IDX_EVT_STATUS, 32'h2, RESP_OKAY);
    chk("irq event cleared", 32'h0, {31'h0, irq});
    rc("event status clear", IDX_EVT_STATUS, 32'h5);
    $display("test event status done");
    report_and_stop();
  end
endmodule : pulse_edge_timer_irq_bench
`default_nettype wire
